// ---- hw/rsc_pkg.sv ----
package rsc_pkg;

    // ------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] RSC_OFF_PC     = 8'h00;
    localparam logic [7:0] RSC_OFF_SP     = 8'h04;
    localparam logic [7:0] RSC_OFF_IX     = 8'h08;
    localparam logic [7:0] RSC_OFF_IY     = 8'h0C;
    localparam logic [7:0] RSC_OFF_IPAGE  = 8'h10;
    localparam logic [7:0] RSC_OFF_REFR   = 8'h14;
    localparam logic [7:0] RSC_OFF_AF     = 8'h18;
    localparam logic [7:0] RSC_OFF_GP0    = 8'h1C;
    localparam logic [7:0] RSC_OFF_AF_ALT = 8'h28;
    localparam logic [7:0] RSC_OFF_GP1    = 8'h2C;
    localparam logic [7:0] RSC_OFF_CMD    = 8'h38;
    localparam logic [7:0] RSC_OFF_STAT   = 8'h3C;
    localparam logic [7:0] RSC_OFF_EADDR  = 8'h40;
    localparam logic [7:0] RSC_OFF_JUMP   = 8'h44;

    // ------------------------------------------------------------
    // Command codes and command word fields
    // ------------------------------------------------------------
    localparam logic [3:0] RSC_CMD_FETCH  = 4'h1;
    localparam logic [3:0] RSC_CMD_JUMP   = 4'h2;
    localparam logic [3:0] RSC_CMD_PUSH   = 4'h3;
    localparam logic [3:0] RSC_CMD_POP    = 4'h4;
    localparam logic [3:0] RSC_CMD_EX_AF  = 4'h5;
    localparam logic [3:0] RSC_CMD_EXX    = 4'h6;
    localparam logic [3:0] RSC_CMD_INDEX  = 4'h7;
    localparam logic [3:0] RSC_CMD_VECTOR = 4'h8;
    localparam logic [3:0] RSC_CMD_ALU    = 4'h9;
    localparam logic [3:0] RSC_CMD_ADD16  = 4'hA;
    localparam int RSC_CMD_OP_POS  = 4;
    localparam int RSC_CMD_DAT_POS = 8;
    localparam int RSC_CMD_BIT_POS = 16;
    localparam int RSC_CMD_IDX_POS = 19;

    // ------------------------------------------------------------
    // ALU operation codes
    // ------------------------------------------------------------
    localparam logic [3:0] RSC_ALU_ADD = 4'h0;
    localparam logic [3:0] RSC_ALU_SUB = 4'h1;
    localparam logic [3:0] RSC_ALU_AND = 4'h2;
    localparam logic [3:0] RSC_ALU_OR  = 4'h3;
    localparam logic [3:0] RSC_ALU_XOR = 4'h4;
    localparam logic [3:0] RSC_ALU_CP  = 4'h5;
    localparam logic [3:0] RSC_ALU_INC = 4'h6;
    localparam logic [3:0] RSC_ALU_DEC = 4'h7;
    localparam logic [3:0] RSC_ALU_SLA = 4'h8;
    localparam logic [3:0] RSC_ALU_SRA = 4'h9;
    localparam logic [3:0] RSC_ALU_SRL = 4'hA;
    localparam logic [3:0] RSC_ALU_RLC = 4'hB;
    localparam logic [3:0] RSC_ALU_RRC = 4'hC;
    localparam logic [3:0] RSC_ALU_SET = 4'hD;
    localparam logic [3:0] RSC_ALU_RES = 4'hE;
    localparam logic [3:0] RSC_ALU_BIT = 4'hF;

    // ------------------------------------------------------------
    // Flag bit positions, reset values, timing
    // ------------------------------------------------------------
    localparam int RSC_FLG_C = 0;
    localparam int RSC_FLG_N = 1;
    localparam int RSC_FLG_Z = 6;
    localparam int RSC_FLG_S = 7;
    localparam logic [15:0] RSC_RST_PC = 16'h0000;
    localparam logic [15:0] RSC_RST_SP = 16'hFFFF;
    localparam logic [1:0]  RSC_RD_WAIT = 2'h2;

    // States of the memory sequencer
    typedef enum logic [1:0] {
        RSC_IDLE,
        RSC_MEMRD,
        RSC_REFRESH
    } rsc_st_e;

    // External memory bus carrier
    typedef struct packed {
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        rd;
        logic        wr;
        logic        rfsh;
    } rsc_mem_s;

endpackage : rsc_pkg

// ---- hw/rsc_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module rsc_core (
    input  wire logic              pclk,     // Clock
    input  wire logic              presetn,  // Async reset, low
    input  wire logic              psel,     // APB select
    input  wire logic              penable,  // APB enable
    input  wire logic              pwrite,   // APB direction
    input  wire logic [7:0]        paddr,    // APB byte address
    input  wire logic [31:0]       pwdata,   // APB write data
    output logic      [31:0]       prdata,   // APB read data
    output logic                   pready,   // APB ready
    output logic                   pslverr,  // APB error
    input  wire logic [7:0]        mem_din,  // Memory read data pin
    output rsc_pkg::rsc_mem_s      mem       // Memory bus outputs
);
    import rsc_pkg::*;

    // ------------------------------------------------------------
    // State record
    // ------------------------------------------------------------
    typedef struct packed {
        rsc_st_e          st;        // Sequencer state
        logic [1:0]       wcnt;      // Read wait count
        logic             is_fetch;  // Read is opcode fetch
        logic [7:0]       din_m;     // Sync stage one
        logic [7:0]       din_s;     // Sync stage two
        logic [15:0]      pc;        // Program counter
        logic [15:0]      sp;        // Stack pointer
        logic [15:0]      ix;        // First index base
        logic [15:0]      iy;        // Second index base
        logic [15:0]      jtgt;      // Jump target
        logic [15:0]      eaddr;     // Effective address
        logic [7:0]       ipage;     // Interrupt page
        logic [7:0]       refr;      // Refresh counter
        logic [7:0]       ir;        // Instruction register
        logic [7:0]       popd;      // Last popped byte
        logic [1:0][15:0] af;        // Accumulator/flag pairs
        logic [1:0][2:0][15:0] gp;   // General banks
        logic             af_sel;    // Active acc pair
        logic             gp_sel;    // Active bank
        rsc_mem_s         mem;       // Memory outputs
        logic [31:0]      prdata;    // Read data
        logic             pready;    // Ready
        logic             pslverr;   // Error
    } rsc_state_s;

    rsc_state_s s_reg;  // Registered state
    rsc_state_s s_next; // Next state

    // ------------------------------------------------------------
    // Helper functions
    // ------------------------------------------------------------
    // Address is a mapped word
    function automatic logic addr_hit(input logic [7:0] a);
        addr_hit = (a[1:0] == 2'h0) && (a <= RSC_OFF_JUMP);
    endfunction

    // Pair index 0..2 from address inside a bank window
    function automatic logic [1:0] pair_idx(input logic [7:0] a,
                                            input logic [7:0] b);
        logic [7:0] d;
        d = a - b;
        pair_idx = d[3:2];
    endfunction

    // Eight-bit ALU: returns {flags, result}
    function automatic logic [15:0] alu8(input logic [3:0] op,
                                         input logic [7:0] a,
                                         input logic [7:0] b,
                                         input logic [2:0] bn,
                                         input logic [7:0] fin);
        logic [8:0] w;
        logic [7:0] f;
        logic [7:0] m;
        w = {1'b0, a};
        f = fin;
        m = 8'h01 << bn;
        f[RSC_FLG_N] = 1'b0;
        case (op)
            RSC_ALU_ADD: w = {1'b0, a} + {1'b0, b};
            RSC_ALU_SUB: w = {1'b0, a} - {1'b0, b};
            RSC_ALU_AND: w = {1'b0, a & b};
            RSC_ALU_OR:  w = {1'b0, a | b};
            RSC_ALU_XOR: w = {1'b0, a ^ b};
            RSC_ALU_CP:  w = {1'b0, a} - {1'b0, b};
            RSC_ALU_INC: w = {f[RSC_FLG_C], a + 8'h01};
            RSC_ALU_DEC: w = {f[RSC_FLG_C], a - 8'h01};
            RSC_ALU_SLA: w = {a, 1'b0};
            RSC_ALU_SRA: w = {a[0], a[7], a[7:1]};
            RSC_ALU_SRL: w = {a[0], 1'b0, a[7:1]};
            RSC_ALU_RLC: w = {a[7], a[6:0], a[7]};
            RSC_ALU_RRC: w = {a[0], a[0], a[7:1]};
            RSC_ALU_SET: w = {f[RSC_FLG_C], a | m};
            RSC_ALU_RES: w = {f[RSC_FLG_C], a & ~m};
            RSC_ALU_BIT: w = {f[RSC_FLG_C], a & m};
            default:     w = {1'b0, a};
        endcase
        // Result conditions
        f[RSC_FLG_C] = w[8];
        f[RSC_FLG_Z] = (w[7:0] == 8'h00);
        f[RSC_FLG_S] = w[7];
        if ((op == RSC_ALU_SUB) || (op == RSC_ALU_CP) ||
            (op == RSC_ALU_DEC)) begin
            f[RSC_FLG_N] = 1'b1;
        end
        // Compare and bit test leave the accumulator alone
        if ((op == RSC_ALU_CP) || (op == RSC_ALU_BIT)) begin
            alu8 = {f, a};
        end else begin
            alu8 = {f, w[7:0]};
        end
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic        acc_wr;   // APB write access phase
        logic        acc_set;  // APB setup phase
        logic [31:0] rd;       // Read mux value
        logic [3:0]  cmd;      // Command code
        logic [3:0]  aop;      // ALU operation
        logic [7:0]  dat;      // Command data byte
        logic [2:0]  bn;       // Bit number
        logic        isel;     // Index select
        logic [15:0] base;     // Chosen index base
        logic [15:0] res;      // ALU output
        logic [16:0] sum16;    // Sixteen-bit add
        logic [1:0]  pi;       // Pair index
        rd = 32'h0000_0000;
        s_next = s_reg;
        acc_set = psel && !penable;
        acc_wr = psel && penable && pwrite && s_reg.pready && addr_hit(paddr);
        cmd = pwdata[RSC_CMD_OP_POS-1:0];
        aop = pwdata[RSC_CMD_OP_POS +: 4];
        dat = pwdata[RSC_CMD_DAT_POS +: 8];
        bn = pwdata[RSC_CMD_BIT_POS +: 3];
        isel = pwdata[RSC_CMD_IDX_POS];
        base = isel ? s_reg.iy : s_reg.ix;
        res = 16'h0000;
        sum16 = 17'h0_0000;
        pi = 2'h0;

        // Sync the memory data pin
        s_next.din_m = mem_din;
        s_next.din_s = s_reg.din_m;
        // Memory strobes last one cycle
        s_next.mem.rd = 1'b0;
        s_next.mem.wr = 1'b0;
        s_next.mem.rfsh = 1'b0;

        // APB response: ready in the access cycle
        s_next.pready = acc_set;
        s_next.pslverr = acc_set && !addr_hit(paddr);

        // Read mux, captured in setup
        if (paddr == RSC_OFF_PC) begin
            rd[15:0] = s_reg.pc;
        end else if (paddr == RSC_OFF_SP) begin
            rd[15:0] = s_reg.sp;
        end else if (paddr == RSC_OFF_IX) begin
            rd[15:0] = s_reg.ix;
        end else if (paddr == RSC_OFF_IY) begin
            rd[15:0] = s_reg.iy;
        end else if (paddr == RSC_OFF_IPAGE) begin
            rd[7:0] = s_reg.ipage;
        end else if (paddr == RSC_OFF_REFR) begin
            rd[7:0] = s_reg.refr;
        end else if (paddr == RSC_OFF_AF) begin
            rd[15:0] = s_reg.af[s_reg.af_sel];
        end else if (paddr == RSC_OFF_AF_ALT) begin
            rd[15:0] = s_reg.af[!s_reg.af_sel];
        end else if (paddr >= RSC_OFF_GP0 && paddr < RSC_OFF_AF_ALT) begin
            pi = pair_idx(paddr, RSC_OFF_GP0);
            rd[15:0] = s_reg.gp[s_reg.gp_sel][pi];
        end else if (paddr >= RSC_OFF_GP1 && paddr < RSC_OFF_CMD) begin
            pi = pair_idx(paddr, RSC_OFF_GP1);
            rd[15:0] = s_reg.gp[!s_reg.gp_sel][pi];
        end else if (paddr == RSC_OFF_STAT) begin
            rd = {12'h000, s_reg.gp_sel, s_reg.af_sel,
                  (s_reg.st != RSC_IDLE), 1'b0,
                  s_reg.popd, s_reg.ir};
        end else if (paddr == RSC_OFF_EADDR) begin
            rd[15:0] = s_reg.eaddr;
        end else if (paddr == RSC_OFF_JUMP) begin
            rd[15:0] = s_reg.jtgt;
        end else begin
            rd = 32'h0000_0000; // Unmapped reads zero
        end
        if (acc_set) begin
            s_next.prdata = addr_hit(paddr) ? rd : 32'h0000_0000;
        end

        // Register writes from software
        if (acc_wr) begin
            if (paddr == RSC_OFF_PC) begin
                s_next.pc = pwdata[15:0];
            end else if (paddr == RSC_OFF_SP) begin
                s_next.sp = pwdata[15:0];
            end else if (paddr == RSC_OFF_IX) begin
                s_next.ix = pwdata[15:0];
            end else if (paddr == RSC_OFF_IY) begin
                s_next.iy = pwdata[15:0];
            end else if (paddr == RSC_OFF_IPAGE) begin
                s_next.ipage = pwdata[7:0];
            end else if (paddr == RSC_OFF_REFR) begin
                s_next.refr = pwdata[7:0];
            end else if (paddr == RSC_OFF_AF) begin
                s_next.af[s_reg.af_sel] = pwdata[15:0];
            end else if (paddr == RSC_OFF_AF_ALT) begin
                s_next.af[!s_reg.af_sel] = pwdata[15:0];
            end else if (paddr >= RSC_OFF_GP0 &&
                         paddr < RSC_OFF_AF_ALT) begin
                pi = pair_idx(paddr, RSC_OFF_GP0);
                s_next.gp[s_reg.gp_sel][pi] = pwdata[15:0];
            end else if (paddr >= RSC_OFF_GP1 &&
                         paddr < RSC_OFF_CMD) begin
                pi = pair_idx(paddr, RSC_OFF_GP1);
                s_next.gp[!s_reg.gp_sel][pi] = pwdata[15:0];
            end else if (paddr == RSC_OFF_JUMP) begin
                s_next.jtgt = pwdata[15:0];
            end
        end

        // Sequencer and commands
        case (s_reg.st)
            RSC_IDLE: begin
                if (acc_wr && paddr == RSC_OFF_CMD) begin
                    case (cmd)
                        RSC_CMD_FETCH: begin
                            // Address out first, then step
                            s_next.mem.addr = s_reg.pc;
                            s_next.mem.rd = 1'b1;
                            s_next.pc = s_reg.pc + 16'h0001;
                            s_next.is_fetch = 1'b1;
                            s_next.wcnt = 2'h0;
                            s_next.st = RSC_MEMRD;
                        end
                        RSC_CMD_JUMP: begin
                            s_next.pc = s_reg.jtgt;
                        end
                        RSC_CMD_PUSH: begin
                            // Stack grows down
                            s_next.sp = s_reg.sp - 16'h0001;
                            s_next.mem.addr = s_reg.sp - 16'h0001;
                            s_next.mem.wdata = dat;
                            s_next.mem.wr = 1'b1;
                        end
                        RSC_CMD_POP: begin
                            // Read the top, then release it
                            s_next.mem.addr = s_reg.sp;
                            s_next.mem.rd = 1'b1;
                            s_next.sp = s_reg.sp + 16'h0001;
                            s_next.is_fetch = 1'b0;
                            s_next.wcnt = 2'h0;
                            s_next.st = RSC_MEMRD;
                        end
                        RSC_CMD_EX_AF: begin
                            s_next.af_sel = !s_reg.af_sel;
                        end
                        RSC_CMD_EXX: begin
                            s_next.gp_sel = !s_reg.gp_sel;
                        end
                        RSC_CMD_INDEX: begin
                            // Sign-extended displacement
                            s_next.eaddr = base +
                                {{8{dat[7]}}, dat};
                        end
                        RSC_CMD_VECTOR: begin
                            s_next.eaddr = {s_reg.ipage, dat};
                        end
                        RSC_CMD_ALU: begin
                            // Operand and result over one shared path
                            res = alu8(aop,
                                s_reg.af[s_reg.af_sel][15:8], dat, bn,
                                s_reg.af[s_reg.af_sel][7:0]);
                            s_next.af[s_reg.af_sel] =
                                {res[7:0], res[15:8]};
                        end
                        RSC_CMD_ADD16: begin
                            // Third pair of active bank plus first, sum into third
                            sum16 = {1'b0, s_reg.gp[s_reg.gp_sel][2]} +
                                    {1'b0, s_reg.gp[s_reg.gp_sel][0]};
                            s_next.gp[s_reg.gp_sel][2] = sum16[15:0];
                            s_next.af[s_reg.af_sel][RSC_FLG_C] =
                                sum16[16];
                            s_next.af[s_reg.af_sel][RSC_FLG_Z] =
                                (sum16[15:0] == 16'h0000);
                        end
                        default: begin
                            s_next.st = RSC_IDLE; // Unknown command
                        end
                    endcase
                end
            end
            RSC_MEMRD: begin
                // Wait for the synchronised read data
                s_next.wcnt = s_reg.wcnt + 2'h1;
                if (s_reg.wcnt == RSC_RD_WAIT) begin
                    if (s_reg.is_fetch) begin
                        s_next.ir = s_reg.din_s;
                        s_next.refr = {s_reg.refr[7],
                            s_reg.refr[6:0] + 7'h01};
                        s_next.mem.addr = {s_reg.ipage,
                            s_reg.refr};
                        s_next.mem.rfsh = 1'b1;
                        s_next.st = RSC_REFRESH;
                    end else begin
                        s_next.popd = s_reg.din_s;
                        s_next.st = RSC_IDLE;
                    end
                end
            end
            RSC_REFRESH: begin
                s_next.st = RSC_IDLE;
            end
            default: begin
                s_next.st = RSC_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // State register
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg <= '0;
            s_reg.st <= RSC_IDLE;
            s_reg.pc <= RSC_RST_PC;
            s_reg.sp <= RSC_RST_SP;
        end else begin
            s_reg <= s_next;
        end
    end

    // Outputs straight from the state flops
    assign prdata = s_reg.prdata;
    assign pready = s_reg.pready;
    assign pslverr = s_reg.pslverr;
    assign mem = s_reg.mem;

endmodule // rsc_core
`default_nettype wire

// ---- test/rsc_core_props.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// Port checker for the register set core
// ------------------------------------------------
module rsc_core_props (
    input wire logic              pclk,    // Clock
    input wire logic              presetn, // Async reset, low
    input wire logic              psel,    // APB select
    input wire logic              penable, // APB enable
    input wire logic [7:0]        paddr,   // APB address
    input wire logic              pready,  // APB ready
    input wire logic              pslverr, // APB error
    input wire rsc_pkg::rsc_mem_s mem      // Memory bus
);
    import rsc_pkg::*;
    wire setup  = psel && !penable;                   // Setup cycle
    wire mapped = paddr <= 8'h44 && paddr[1:0] == 2'h0; // Decoded word
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Bus answers one cycle after setup, for one cycle only
    a_ready_next: assert property (setup |=> pready)
        else $error("no ready after setup");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready longer than one cycle");
    a_err_unmapped: assert property (setup && !mapped |=> pslverr)
        else $error("unmapped access not refused");
    a_err_mapped: assert property (setup && mapped |=> !pslverr)
        else $error("mapped access refused");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("error without ready");
    // Memory strobes are single pulses, refresh trails the fetch
    a_read_pulse: assert property (mem.rd |=> !mem.rd)
        else $error("read strobe too long");
    a_write_pulse: assert property (mem.wr |=> !mem.wr)
        else $error("write strobe too long");
    a_refresh_late: assert property (mem.rfsh |-> $past(mem.rd, 3))
        else $error("refresh not three cycles after read");
    a_refresh_pulse: assert property (mem.rfsh |=> !mem.rfsh)
        else $error("refresh strobe too long");
    a_addr_hold: assert property (mem.addr != $past(mem.addr) |->
        mem.rd || mem.wr || mem.rfsh) else $error("address moved alone");
    c_fetch: cover property (mem.rfsh);
    c_push: cover property (mem.wr);
    c_error: cover property (pslverr);
endmodule // rsc_core_props
`default_nettype wire

// ---- test/rsc_mem_model.sv ----
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------
// External memory on the far side of the core
// ------------------------------------------------
module rsc_mem_model (
    input  wire logic              pclk,   // Clock
    input  wire rsc_pkg::rsc_mem_s mem,    // Bus from core
    output logic [7:0]             mem_din // Read data
);
    import rsc_pkg::*;
    logic [7:0] ram [0:65535]; // Byte store, known pattern
    logic [2:0] win = 3'h0;    // Cycles left of read drive
    initial for (int i = 0; i < 65536; i++) ram[i] = 8'(i) ^ 8'hA5;
    // Store on write strobe, hold read data a few cycles
    always @(posedge pclk) begin
        if (mem.wr) ram[mem.addr] <= mem.wdata;
        win <= mem.rd ? 3'h4 : (win != 3'h0 ? win - 3'h1 : 3'h0);
    end
    // Outside a read the pins float: show the inverse
    assign mem_din = (mem.rd || win != 3'h0) ? ram[mem.addr]
                                             : ~ram[mem.addr];
endmodule // rsc_mem_model
`default_nettype wire

// ---- test/test_cpu_register_set_core.sv ----
`timescale 1ns/1ns
`default_nettype none
module test_cpu_register_set_core;
    import rsc_pkg::*;
    typedef struct {logic r; logic [31:0] d, m; logic e;} rsc_note_s;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0;
    logic        penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [7:0]  paddr = 8'h00, mem_din, d, a, r;
    logic [31:0] pwdata = 32'h0, prdata;
    rsc_mem_s    mem;            // Memory bus
    rsc_note_s   nq[$];          // Expected bus answers
    logic [26:0] mq[$];          // Expected memory strobes
    logic [15:0] rv [18];        // Register model
    logic [7:0]  pv [2];         // Pushed bytes
    int          mismatches = 0, n_checks = 0;
    rsc_core i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .mem_din, .mem);
    rsc_mem_model i_mem (.pclk, .mem, .mem_din);
    initial forever #50 pclk = ~pclk;
    // ------------------------------------------------
    // Checking and closing
    // ------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // One APB transfer, then an idle cycle
    task automatic apb(input logic w, input logic [7:0] ad,
                       input logic [31:0] dat, m, input logic e);
        int n;
        nq.push_back('{!w, dat, m, e});
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= dat;
        @(posedge pclk) penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) mismatches++;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] ad, input logic [31:0] dat);
        apb(1'b1, ad, dat, 32'h0, 1'b0);
    endtask
    task automatic rd(input logic [7:0] ad, input logic [31:0] x, m = '1);
        apb(1'b0, ad, x, m, 1'b0);
    endtask
    // Fetch at pc: read strobe, then refresh at page and counter
    task automatic fetch;
        mq.push_back({rv[0], 8'h00, 3'b100});
        mq.push_back({rv[4][7:0], rv[5][7:0], 8'h00, 3'b001});
        wr(8'h38, {28'h0, RSC_CMD_FETCH});
        repeat (6) @(posedge pclk);
        rd(8'h3C, {24'h0, rv[0][7:0] ^ 8'hA5}, 32'hFF);
        rv[0]++;
        rv[5] = {8'h0, rv[5][7], rv[5][6:0] + 7'h1};
        rd(8'h00, {16'h0, rv[0]});
        rd(8'h14, {16'h0, rv[5]});
    endtask
    // ------------------------------------------------
    // Monitors: oldest note against each answer
    // ------------------------------------------------
    always @(posedge pclk) if (psel && penable && pready === 1'b1) begin
        rsc_note_s n;
        n = nq.pop_front();
        if (n.r) chk(prdata & n.m, n.d & n.m);
        chk({31'h0, pslverr}, {31'h0, n.e});
    end
    always @(posedge pclk) if ((mem.rd | mem.wr | mem.rfsh) === 1'b1)
        chk({mem.addr, mem.wr ? mem.wdata : 8'h00, mem.rd, mem.wr, mem.rfsh},
            mq.size() ? mq.pop_front() : 27'h0);
    initial begin
        #3_000_000;
        mismatches++;
        finish_test();
    end
    // ------------------------------------------------
    // Scenarios
    // ------------------------------------------------
    initial begin
        void'($urandom(32'hD253BD16));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 18; i++)
            rd(8'(i * 4), i == 1 ? 32'hFFFF : 32'h0);
        for (int i = 0; i < 18; i++) if (i < 14 || i == 17) begin
            rv[i] = 16'($urandom) & (i == 4 || i == 5 ? 16'hFF : 16'hFFFF);
            wr(8'(i * 4), {16'h0, rv[i]});
        end
        for (int i = 0; i < 18; i++) if (i < 14 || i == 17)
            rd(8'(i * 4), {16'h0, rv[i]});
        apb(1'b0, 8'h48 + 8'($urandom % 46) * 8'h4, 32'h0, '1, 1'b1);
        apb(1'b1, 8'h06, 32'h0, 32'h0, 1'b1);
        rv[5] = 16'hFF;
        wr(8'h14, 32'hFF);
        fetch();
        fetch();
        wr(8'h38, {28'h0, RSC_CMD_JUMP});
        rv[0] = rv[17];
        fetch();
        for (int k = 0; k < 2; k++) begin
            pv[k] = 8'($urandom);
            rv[1]--;
            mq.push_back({rv[1], pv[k], 3'b010});
            wr(8'h38, {16'h0, pv[k], 4'h0, RSC_CMD_PUSH});
        end
        for (int k = 1; k >= 0; k--) begin
            mq.push_back({rv[1], 8'h00, 3'b100});
            wr(8'h38, {28'h0, RSC_CMD_POP});
            repeat (4) @(posedge pclk);
            rv[1]++;
            rd(8'h3C, {16'h0, pv[k], 8'h0}, 32'hFF00);
        end
        rd(8'h04, {16'h0, rv[1]});
        for (int k = 0; k < 2; k++) begin
            d = 8'($urandom) ^ (k ? 8'h00 : 8'h80);
            wr(8'h38, {12'h0, k[0], 3'h0, d, 4'h0, RSC_CMD_INDEX});
            rd(8'h40, {16'h0, rv[2 + k] + {{8{d[7]}}, d}});
        end
        wr(8'h38, {16'h0, d, 4'h0, RSC_CMD_VECTOR});
        rd(8'h40, {16'h0, rv[4][7:0], d});
        wr(8'h38, {28'h0, RSC_CMD_EX_AF});
        wr(8'h38, {28'h0, RSC_CMD_EXX});
        for (int i = 6; i < 10; i++) {rv[i], rv[i + 4]} = {rv[i + 4], rv[i]};
        rd(8'h3C, 32'hC0000, 32'hC0000);
        for (int i = 6; i < 14; i++)
            rd(8'(i * 4), {16'h0, rv[i]});
        for (int k = 0; k < 4; k++) begin
            a = rv[6][15:8];
            d = k > 1 ? a : 8'($urandom);
            r = k == 0 ? a & d : k == 1 ? a | d : k == 2 ? a ^ d : a;
            wr(8'h38, {16'h0, d, k == 0 ? RSC_ALU_AND : k == 1 ? RSC_ALU_OR :
                k == 2 ? RSC_ALU_XOR : RSC_ALU_CP, RSC_CMD_ALU});
            rv[6][15:8] = r;
            rd(8'h18, {16'h0, r, k < 3 && r[7], k > 1 || r == 8'h0, 6'h0},
               32'hFFC0);
        end
        for (int k = 6; k < 16; k++) begin
            a = rv[6][15:8];
            d = 8'h01 << 3'(k);
            r = k == 6 ? a + 8'h1 : k == 7 ? a - 8'h1 : k == 8 ? a << 1 :
                k == 9 ? {a[7], a[7:1]} : k == 10 ? a >> 1 :
                k == 11 ? {a[6:0], a[7]} : k == 12 ? {a[0], a[7:1]} :
                k == 13 ? a | d : k == 14 ? a & ~d : a;
            wr(8'h38, {13'h0, 3'(k), 8'h0, 4'(k), RSC_CMD_ALU});
            rv[6][15:8] = r;
            rd(8'h18, {16'h0, r, 1'b0, k > 14 ? !(a & d) : r == 8'h0,
               6'h0}, 32'hFF40);
        end
        wr(8'h24, 32'hFFFF);
        wr(8'h1C, 32'h1);
        wr(8'h38, {28'h0, RSC_CMD_ADD16});
        rd(8'h24, 32'h0);
        rd(8'h18, 32'h41, 32'h41);
        finish_test();
    end
endmodule // test_cpu_register_set_core
bind rsc_core rsc_core_props i_props (.pclk, .presetn, .psel, .penable,
    .paddr, .pready, .pslverr, .mem);
`default_nettype wire
